// ---- design/sync_sram_addr_write_ctrl.v ----
// input control of a pipelined synchronous burst sram: address, burst, writes
// How it works
// - all synchronous inputs captured on rising clock only
// - address loads on strobe with chips enabled
// - low address bits seed two-bit burst counter
// - burst counter advances only when advance low
// - lane selects count only with lane write enable
// - global write writes every lane, ignoring selects
// - primary enable active low joins selection
// - processor strobe ignored while primary enable high
// - expansion high enable joins the selection
// - enables examined only on external address loads
// - both strobes low with primary enable low: processor strobe wins
// - expansion low enable joins the selection
// - strap picks linear or interleaved burst order
// - read data appears three cycles after address
`include "sram_ctrl_defines.vh"
module sync_sram_addr_write_ctrl
#(
  parameter ADDR_W = `ADDR_W,
  parameter LANES  = `LANES,
  parameter LANE_W = `LANE_W
)
(
  input  wire                    ref_clk_i,
  input  wire                    rst_n_i,
  input  wire [ADDR_W-1:0]       addr_i,
  input  wire                    proc_addr_strobe_n_i,
  input  wire                    ctrl_addr_strobe_n_i,
  input  wire                    burst_advance_n_i,
  input  wire                    chip_sel_primary_n_i,
  input  wire                    chip_sel_expand_hi_i,
  input  wire                    chip_sel_expand_lo_n_i,
  input  wire [LANES-1:0]        lane_write_sel_n_i,
  input  wire                    lane_write_en_n_i,
  input  wire                    all_lanes_write_n_i,
  input  wire                    burst_mode_i,
  input  wire [LANES*LANE_W-1:0] wdata_i,
  output reg  [LANES*LANE_W-1:0] rdata_o,
  output reg                     rdata_valid_o,
  output reg                     selected_o,
  output reg  [ADDR_W-1:0]       cur_addr_o
);
  // linear adds, interleaved xors the count into the seed
  function [1:0] burst_addr;
    input [1:0] seed;
    input [1:0] cnt;
    input       interleave;
    begin
      if (interleave)
        burst_addr = seed ^ cnt;
      else
        burst_addr = seed + cnt;
    end
  endfunction

  reg  [2:0]              state_r;
  reg  [2:0]              state_nxt;
  reg  [ADDR_W-1:0]       base_r;
  reg  [`SEED_W-1:0]      burst_seed_bits_r;
  reg  [`SEED_W-1:0]      cnt_r;
  reg                     mode_r;
  reg                     rd_pend_r;
  reg                     rd_arr_r;
  reg  [LANES-1:0]        wr_lane;
  reg  [LANES*LANE_W-1:0] wdata_r;
  reg  [ADDR_W-1:0]       mem_addr;
  reg  [LANES-1:0]        wr_lane_r;
  wire [LANES*LANE_W-1:0] arr_rdata;
  wire                    chips_on;
  wire                    proc_load;
  wire                    ctrl_load;
  wire                    load;
  wire                    ext_start;
  wire                    advance;
  wire                    write_cyc;
  wire                    beat;

  // all three enables must agree; looked at only on load edges
  assign chips_on  = ~chip_sel_primary_n_i & chip_sel_expand_hi_i &
                     ~chip_sel_expand_lo_n_i;
  // processor strobe needs the primary enable; takes priority over controller strobe
  assign proc_load = ~proc_addr_strobe_n_i & ~chip_sel_primary_n_i;
  // an ignored processor strobe leaves the controller strobe in charge
  assign ctrl_load = ~proc_load & ~ctrl_addr_strobe_n_i;
  assign load      = proc_load | ctrl_load;
  assign ext_start = load & chips_on;
  assign advance   = (state_r == `ST_ACTIVE) & ~load & ~burst_advance_n_i;
  // processor strobe cycle is always a read; writes follow on later cycles
  assign write_cyc = ~proc_load & (~all_lanes_write_n_i | ~lane_write_en_n_i);
  // a beat is a fresh load or one advance step; idle active cycles read nothing
  assign beat      = ext_start | advance;

  always @*
  begin
    // global write overrides the lane selects and their enable
    if (~all_lanes_write_n_i)
      wr_lane = {LANES{1'b1}};
    else if (~lane_write_en_n_i)
      wr_lane = ~lane_write_sel_n_i;
    else
      wr_lane = {LANES{1'b0}};
  end

  always @*
  begin
    case (state_r)
      `ST_IDLE:   state_nxt = ext_start ? `ST_ACTIVE : `ST_IDLE;
      // an unqualified load ends the burst; burst cycles keep the state
      `ST_ACTIVE: state_nxt = ext_start ? `ST_ACTIVE : (load ? `ST_DESEL : `ST_ACTIVE);
      `ST_DESEL:  state_nxt = ext_start ? `ST_ACTIVE : `ST_DESEL;
      default:    state_nxt = `ST_IDLE;
    endcase
  end

  always @*
  begin
    mem_addr = base_r;
    mem_addr[1:0] = burst_addr(burst_seed_bits_r, cnt_r, mode_r);
  end

  // strap caught at the clocked reset, static afterward
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      mode_r <= burst_mode_i;
  end

  // state register; enables matter only on load edges
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      state_r <= `ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // address register and two-bit burst counter
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      base_r            <= {ADDR_W{1'b0}};
      burst_seed_bits_r <= `SEED_RST;
      cnt_r             <= `SEED_RST;
    end
    else if (ext_start)
    begin
      base_r            <= addr_i;
      burst_seed_bits_r <= addr_i[1:0];
      cnt_r             <= `SEED_RST;
    end
    else if (advance)
    begin
      cnt_r <= cnt_r + 2'h1;
    end
  end

  // writes land one edge later at the address loaded or advanced by the request edge
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_lane_r <= {LANES{1'b0}};
      wdata_r   <= {(LANES*LANE_W){1'b0}};
    end
    else
    begin
      wr_lane_r <= (state_nxt == `ST_ACTIVE && write_cyc) ? wr_lane : {LANES{1'b0}};
      wdata_r   <= wdata_i;
    end
  end

  // read flag follows the data: beat edge, array edge, output edge
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_pend_r <= 1'b0;
      rd_arr_r  <= 1'b0;
    end
    else
    begin
      rd_pend_r <= beat & ~write_cyc;
      rd_arr_r  <= rd_pend_r;
    end
  end

  // every output straight from a flop, valid aligned with its data
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_valid_o <= 1'b0;
      rdata_o       <= {(LANES*LANE_W){1'b0}};
      selected_o    <= 1'b0;
      cur_addr_o    <= {ADDR_W{1'b0}};
    end
    else
    begin
      rdata_valid_o <= rd_arr_r;
      rdata_o       <= arr_rdata;
      selected_o    <= (state_r == `ST_ACTIVE);
      cur_addr_o    <= mem_addr;
    end
  end

  sram_array
  #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  )
  u_array
  (
    .ref_clk_i (ref_clk_i),
    .addr_i    (mem_addr),
    .wr_lane_i (wr_lane_r),
    .wdata_i   (wdata_r),
    .rdata_o   (arr_rdata)
  );
endmodule

// ---- design/sram_ctrl_defines.vh ----
// constants for the synchronous burst sram input control block
`ifndef SRAM_CTRL_DEFINES_VH
`define SRAM_CTRL_DEFINES_VH
`define ADDR_W        20
`define LANES         2
`define LANE_W        9
`define SEED_W        2
`define SEED_RST      2'h0
`define ST_IDLE       3'h1
`define ST_ACTIVE     3'h2
`define ST_DESEL      3'h4
`endif

// ---- design/sram_array.v ----
// lane-writable memory array with registered read data
module sram_array
#(
  parameter ADDR_W = 20,
  parameter LANES  = 2,
  parameter LANE_W = 9
)
(
  input  wire                      ref_clk_i,
  input  wire [ADDR_W-1:0]         addr_i,
  input  wire [LANES-1:0]          wr_lane_i,
  input  wire [LANES*LANE_W-1:0]   wdata_i,
  output reg  [LANES*LANE_W-1:0]   rdata_o
);
  reg [LANES*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];
  integer i;

  always @(posedge ref_clk_i)
  begin
    for (i = 0; i < LANES; i = i + 1)
    begin
      if (wr_lane_i[i])
        mem[addr_i][i*LANE_W +: LANE_W] <= wdata_i[i*LANE_W +: LANE_W];
    end
    rdata_o <= mem[addr_i];
  end
endmodule

// ---- verification/sram_chk_properties.sv ----
// port assertions for the sram input control block
module sram_chk #(parameter ADDR_W = 20)
(
  input wire              ref_clk_i,
  input wire              rst_n_i,
  input wire [ADDR_W-1:0] addr_i,
  input wire              proc_addr_strobe_n_i,
  input wire              ctrl_addr_strobe_n_i,
  input wire              burst_advance_n_i,
  input wire              chip_sel_primary_n_i,
  input wire              chip_sel_expand_hi_i,
  input wire              chip_sel_expand_lo_n_i,
  input wire              all_lanes_write_n_i,
  input wire              lane_write_en_n_i,
  input wire              rdata_valid_o,
  input wire              selected_o,
  input wire [ADDR_W-1:0] cur_addr_o
);
  timeunit 1ns / 1ns;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire en = !chip_sel_primary_n_i && chip_sel_expand_hi_i && !chip_sel_expand_lo_n_i;
  wire ps = !proc_addr_strobe_n_i && !chip_sel_primary_n_i;
  wire cs = !ps && !ctrl_addr_strobe_n_i;
  wire burst_advance_n = !burst_advance_n_i && proc_addr_strobe_n_i && ctrl_addr_strobe_n_i;
  sequence load_s; (ps || cs) && en; endsequence
  sequence step_s; ps && en ##1 burst_advance_n && all_lanes_write_n_i && lane_write_en_n_i; endsequence
  rd_beat_a: assert property (ps && en |-> ##3 rdata_valid_o) else $error("no beat");
  adv_step_a: assert property (step_s |-> ##3 rdata_valid_o) else $error("no step");
  gw_write_a: assert property (cs && en && !all_lanes_write_n_i |-> ##3 !rdata_valid_o)
    else $error("write read");
  desel_a: assert property ((ps || cs) && !en |-> ##3 !rdata_valid_o) else $error("desel");
  ign_proc_a: assert property (!proc_addr_strobe_n_i && chip_sel_primary_n_i && !cs && burst_advance_n_i
    |-> ##3 !rdata_valid_o) else $error("proc strobe");
  addr_cap_a: assert property (load_s |-> ##2 cur_addr_o == $past(addr_i, 2)) else $error("addr");
  sel_state_a: assert property (load_s |-> ##2 selected_o) else $error("not selected");
  rst_clear_a: assert property (@(posedge ref_clk_i) disable iff (1'b0) !rst_n_i
    |=> !rdata_valid_o && !selected_o) else $error("reset");
endmodule
bind sync_sram_addr_write_ctrl sram_chk #(.ADDR_W(ADDR_W)) sram_chk_i (
  .ref_clk_i              (ref_clk_i),
  .rst_n_i                (rst_n_i),
  .addr_i                 (addr_i),
  .proc_addr_strobe_n_i   (proc_addr_strobe_n_i),
  .ctrl_addr_strobe_n_i   (ctrl_addr_strobe_n_i),
  .burst_advance_n_i      (burst_advance_n_i),
  .chip_sel_primary_n_i   (chip_sel_primary_n_i),
  .chip_sel_expand_hi_i   (chip_sel_expand_hi_i),
  .chip_sel_expand_lo_n_i (chip_sel_expand_lo_n_i),
  .all_lanes_write_n_i    (all_lanes_write_n_i),
  .lane_write_en_n_i      (lane_write_en_n_i),
  .rdata_valid_o          (rdata_valid_o),
  .selected_o             (selected_o),
  .cur_addr_o             (cur_addr_o)
);

// ---- verification/bus_master_model.sv ----
// bus master model: changes the sram inputs just after each rising edge
module bus_master_model
(
  input  wire         ref_clk_i,
  output logic [3:0]  addr_o = 4'h0,
  output logic [9:0]  ctl_o = 10'h3af,
  output logic [17:0] wdata_o = 18'h0
);
  timeunit 1ns / 1ns;
  task cyc(input logic [3:0] a, input logic [9:0] c, input logic [17:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    ctl_o <= c;
    wdata_o <= d;
  endtask
endmodule

// ---- verification/sync_sram_addr_write_ctrl_tb_top.sv ----
// testbench: lane writes, strobe priority, deselects and bursts
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("BAD %0t value mismatch", $time); end end
module sync_sram_addr_write_ctrl_tb_top;
  timeunit 1ns / 1ns;
  // ctl bits: proc, ctrl, adv, ce1, ce2, ce3, global, lane en, lane sel
  localparam logic [9:0] IDL = 10'h3af, RD = 10'h1af, BURST_ADVANCE_N = 10'h32f;
  logic ref_clk = 1'b0, rst_n = 1'b0, mode = 1'b0;
  int err_count, cmp_count;
  wire [3:0] addr, cur;
  wire [9:0] c;
  wire [17:0] wd, rd;
  wire vld, sel;
  logic [49:0] rows [4] = '{{10'h2a7, 4'h1, 18'h2aaaa, 18'h2aaaa}, {10'h2aa, 4'h1, 18'h3ffff,
    18'h2abff}, {10'h2ac, 4'h1, 18'h0, 18'h2abff}, {10'h2a9, 4'h1, 18'h0, 18'h001ff}};
  logic [9:0] dsl [5] = '{10'h1ef, 10'h28f, 10'h2bf, 10'h2ef, 10'h0ef};
  always #5 ref_clk = ~ref_clk;
  bus_master_model bus_master_model_i (.ref_clk_i(ref_clk), .addr_o(addr), .ctl_o(c), .wdata_o(wd));
  sync_sram_addr_write_ctrl #(.ADDR_W(4)) sync_sram_addr_write_ctrl_i (.ref_clk_i(ref_clk),
    .rst_n_i(rst_n), .addr_i(addr), .proc_addr_strobe_n_i(c[9]), .ctrl_addr_strobe_n_i(c[8]),
    .burst_advance_n_i(c[7]), .chip_sel_primary_n_i(c[6]), .chip_sel_expand_hi_i(c[5]),
    .chip_sel_expand_lo_n_i(c[4]), .all_lanes_write_n_i(c[3]), .lane_write_en_n_i(c[2]),
    .lane_write_sel_n_i(c[1:0]), .burst_mode_i(mode), .wdata_i(wd), .rdata_o(rd),
    .rdata_valid_o(vld), .selected_o(sel), .cur_addr_o(cur));
  task rst(input logic m);
    mode <= m;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 `CHK({vld, sel, cur, rd}, 24'h0)
  endtask
  // data lines show the inverse once released
  task wr(input logic [3:0] a, input logic [9:0] w, input logic [17:0] d);
    bus_master_model_i.cyc(a, w, d);
    bus_master_model_i.cyc(a, IDL, ~d);
  endtask
  task rdchk(input logic [3:0] a, input logic [9:0] r, input logic v, input logic [17:0] e);
    bus_master_model_i.cyc(a, r, 18'h0);
    repeat (3) bus_master_model_i.cyc(a, IDL, 18'h0);
    #1 `CHK(vld, v)
    if (v) `CHK(rd, e)
  endtask
  task stop_test();
    $display("mismatches %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    rst(1'b0);
    foreach (rows[i])
    begin
      wr(rows[i][39:36], rows[i][49:40], rows[i][35:18]);
      rdchk(rows[i][39:36], RD, 1'b1, rows[i][17:0]);
    end
    $display("lane writes done");
    rdchk(4'h1, 10'h0a7, 1'b1, 18'h001ff);
    rdchk(4'h1, RD, 1'b1, 18'h001ff);
    $display("strobe priority done");
    foreach (dsl[i]) rdchk(4'h1, dsl[i], 1'b0, 18'h0);
    $display("deselect done");
    for (int m = 0; m < 2; m++)
    begin
      rst(1'(m));
      for (int k = 0; k < 4; k++) wr(4'(4 + k), 10'h2a7, 18'(16 + k));
      bus_master_model_i.cyc(4'h5, RD, 18'h0);
      repeat (2) bus_master_model_i.cyc(4'h0, BURST_ADVANCE_N, 18'h0);
      for (int k = 0; k < 4; k++)
      begin
        bus_master_model_i.cyc(4'h0, (k == 0) ? BURST_ADVANCE_N : IDL, 18'h0);
        #1 `CHK(rd, 18'h10 + 18'(m ? 1 ^ k : (1 + k) & 3))
        `CHK(vld, 1'b1)
      end
    end
    $display("burst done");
    stop_test();
  end
  initial
  begin
    #20000;
    err_count++;
    stop_test();
  end
endmodule
